// ==== hdl/ite_consts.svh ====
// constants for the trim memory access block: offsets, fields, codes, timings
// assumes inclusion by bare name from every design file that needs them
`ifndef ITE_CONSTS_SVH
`define ITE_CONSTS_SVH

// =============================================
// clock and timing
`define ITE_CLK_MHZ          100
`define ITE_STARTUP_TIME_US  300
`define ITE_STARTUP_CYC      (`ITE_STARTUP_TIME_US * `ITE_CLK_MHZ)
`define ITE_PROG_TIME_US     5000
`define ITE_PROG_CYC         (`ITE_PROG_TIME_US * `ITE_CLK_MHZ)

// =============================================
// bus address: upper five bits are arbitrary, low two come from pins
`define ITE_SLAVE_BASE       5'h0e

// =============================================
// register offsets
`define ITE_ADDR_STATUS      8'hc0
`define ITE_ADDR_MODE        8'he0
`define ITE_ADDR_XGAIN       8'he4
`define ITE_ADDR_YGAIN       8'he5
`define ITE_ADDR_ZGAIN       8'he6

// =============================================
// memory map
`define ITE_ADDR_BATCH       8'h60
`define ITE_ADDR_TEMP_OFS    8'h62
`define ITE_ADDR_REF_TRIM    8'h63
`define ITE_ADDR_DRV_TRIM    8'h64
`define ITE_ADDR_TEST_WORD   8'h65
`define ITE_ADDR_XG_TRIM     8'h66
`define ITE_ADDR_YG_TRIM     8'h67
`define ITE_ADDR_ZG_TRIM     8'h68
`define ITE_NUM_WORDS        7
`define ITE_TRIM_DEFAULT     8'h00

// =============================================
// fields and codes
`define ITE_MS_WEN_MSB       7
`define ITE_MS_WEN_LSB       3
`define ITE_MS_MODE_MSB      1
`define ITE_ST_WR_BIT        1
`define ITE_WEN_KEY          5'h15
`define ITE_MODE_MEAS        2'h0
`define ITE_MODE_PROHIB      2'h1
`define ITE_MODE_MEM         2'h2
`define ITE_MODE_PDN         2'h3
`define ITE_GAIN_RST         4'h0

`endif

// ==== hdl/ite_pkg.sv ====
// types shared by the trim memory access block
// assumes nothing of its surroundings
package ite_pkg;

  // =============================================
  // bus transfer states
  typedef enum logic [3:0] {
    st_idle,
    st_rx_dev,
    st_ack_dev,
    st_rx_wa,
    st_ack_wa,
    st_rx_dat,
    st_ack_dat,
    st_tx,
    st_mack
  } ite_state_e;

  // =============================================
  // bus line events, one cycle each
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } ite_line_ev_s;

endpackage

// ==== hdl/ite_line_mon.sv ====
// bus line monitor: clock edges, start and stop conditions
// assumes scl and sda are already synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module ite_line_mon
  import ite_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  // bus lines
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  // events
  output ite_line_ev_s ev
);

  logic scl_q_ff;
  logic sda_q_ff;

  // =============================================
  // previous line levels, idle bus is high
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
    end
  end

  // sda moving while scl stays high marks start or stop
  assign ev.scl_rise = scl_in & ~scl_q_ff;
  assign ev.scl_fall = ~scl_in & scl_q_ff;
  assign ev.start    = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
  assign ev.stop     = scl_in & scl_q_ff & ~sda_q_ff & sda_in;

endmodule
`default_nettype wire

// ==== hdl/ite_eeprom_access.sv ====
// trim memory access: i2c slave, mode register, unlock gate, word counter, programming cycle
// assumes scl/sda synchronous to sys_clk and an external open-drain pull-up on sda
`include "ite_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ite_eeprom_access
  import ite_pkg::*;
#(
  parameter int STARTUP_CYCLES = `ITE_STARTUP_CYC,
  parameter int PROG_CYCLES    = `ITE_PROG_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // i2c pins, sda open drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // address-select straps
  input  wire logic       addr_select_0,
  input  wire logic       addr_select_1,
  // trim words wired into analog
  output logic [7:0]      temp_offset_trim,
  output logic [7:0]      reference_trim,
  output logic [7:0]      drive_oscillator_trim,
  // axis gain settings
  output logic [3:0]      x_axis_gain_reg,
  output logic [3:0]      y_axis_gain_reg,
  output logic [3:0]      z_axis_gain_reg,
  // mode and programming state
  output logic [1:0]      op_mode,
  output logic            ref_ready,
  output logic            hv_prog_on
);

  // =============================================
  // declarations
  ite_line_ev_s ev;
  ite_state_e   state_ff;
  logic [3:0]   bitcnt_ff;
  logic [7:0]   shreg_ff;
  logic         rw_ff;
  logic [7:0]   ptr_ff;
  logic         drv_n_ff;
  logic [1:0]   mode_ff;
  logic [4:0]   wen_ff;
  logic [3:0]   xgain_ff;
  logic [3:0]   ygain_ff;
  logic [3:0]   zgain_ff;
  logic [15:0]  start_cnt_ff;
  logic         ready_ff;
  logic         pend_ff;
  logic [7:0]   pend_addr_ff;
  logic [7:0]   pend_data_ff;
  logic         prog_ff;
  logic [19:0]  prog_cnt_ff;
  logic [7:0]   mem_ff [`ITE_NUM_WORDS];
  logic [6:0]   my_addr;
  logic         mem_on;
  logic         unlocked;
  logic         byte_in;
  logic         reg_we;
  logic         mem_we;
  logic [7:0]   tx_byte;

  // =============================================
  // line events, bit rate set by scl edges alone
  ite_line_mon u_line_mon (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ev      (ev)
  );

  // =============================================
  // address helpers
  function automatic logic is_mem(input logic [7:0] a);
    is_mem = (a == `ITE_ADDR_BATCH) ||
             (a >= `ITE_ADDR_TEMP_OFS && a <= `ITE_ADDR_ZG_TRIM);
  endfunction

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == `ITE_ADDR_STATUS) || (a == `ITE_ADDR_MODE) ||
             (a >= `ITE_ADDR_XGAIN && a <= `ITE_ADDR_ZGAIN);
  endfunction

  // counter step, wrapping inside the trim words
  function automatic logic [7:0] step(input logic [7:0] a);
    if (a == `ITE_ADDR_ZG_TRIM) begin
      step = `ITE_ADDR_TEMP_OFS;
    end else begin
      step = a + 8'h01;
    end
  endfunction

  function automatic logic [2:0] widx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `ITE_ADDR_TEMP_OFS;
    widx = d[2:0];
  endfunction

  assign my_addr  = {`ITE_SLAVE_BASE, addr_select_1, addr_select_0};
  assign mem_on   = (mode_ff == `ITE_MODE_MEM) && ready_ff;
  assign unlocked = (wen_ff == `ITE_WEN_KEY);
  assign byte_in  = ev.scl_fall && (bitcnt_ff == 4'h8);

  // data byte commits: registers at once, memory after stop
  assign reg_we = (state_ff == st_rx_dat) && byte_in && is_reg(ptr_ff) &&
                  (ptr_ff != `ITE_ADDR_STATUS);
  assign mem_we = (state_ff == st_rx_dat) && byte_in && is_mem(ptr_ff) &&
                  mem_on && unlocked;

  // =============================================
  // read data mux, outside the map reads zero
  always_comb begin
    tx_byte = 8'h00;
    if (ptr_ff == `ITE_ADDR_STATUS) begin
      tx_byte[`ITE_ST_WR_BIT] = unlocked;
    end else if (ptr_ff == `ITE_ADDR_MODE) begin
      tx_byte = {wen_ff, 1'b0, mode_ff};
    end else if (ptr_ff == `ITE_ADDR_XGAIN) begin
      tx_byte = {4'h0, xgain_ff};
    end else if (ptr_ff == `ITE_ADDR_YGAIN) begin
      tx_byte = {4'h0, ygain_ff};
    end else if (ptr_ff == `ITE_ADDR_ZGAIN) begin
      tx_byte = {4'h0, zgain_ff};
    end else if (mem_on && ptr_ff >= `ITE_ADDR_TEMP_OFS && ptr_ff <= `ITE_ADDR_ZG_TRIM) begin
      tx_byte = mem_ff[widx(ptr_ff)];
    end
  end

  // =============================================
  // bus transfer state machine
  // stop beats start beats clock edges; a stop always frees sda
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff  <= st_idle;
      bitcnt_ff <= 4'h0;
      shreg_ff  <= 8'h00;
      rw_ff     <= 1'b0;
      ptr_ff    <= `ITE_ADDR_TEMP_OFS;
      drv_n_ff  <= 1'b1;
    end else if (ev.stop) begin
      state_ff <= st_idle;
      drv_n_ff <= 1'b1;
    end else if (ev.start) begin
      state_ff  <= st_rx_dev; // repeated start too
      bitcnt_ff <= 4'h0;
      drv_n_ff  <= 1'b1;
    end else begin
      if (ev.scl_rise && (state_ff == st_rx_dev || state_ff == st_rx_wa ||
                          state_ff == st_rx_dat || state_ff == st_tx)) begin
        bitcnt_ff <= bitcnt_ff + 4'h1;
        if (state_ff != st_tx) begin
          shreg_ff <= {shreg_ff[6:0], sda_in};
        end
      end
      case (state_ff)
        st_idle: begin
          drv_n_ff <= 1'b1;
        end
        st_rx_dev: begin
          if (byte_in) begin
            // busy programming: look absent rather than corrupt the cycle
            if (shreg_ff[7:1] == my_addr && !prog_ff) begin
              rw_ff    <= shreg_ff[0];
              drv_n_ff <= 1'b0;
              state_ff <= st_ack_dev;
            end else begin
              state_ff <= st_idle;
            end
          end
        end
        st_ack_dev: begin
          if (ev.scl_fall) begin
            bitcnt_ff <= 4'h0;
            if (rw_ff) begin
              shreg_ff <= tx_byte;
              drv_n_ff <= tx_byte[7];
              ptr_ff   <= step(ptr_ff);
              state_ff <= st_tx;
            end else begin
              drv_n_ff <= 1'b1;
              state_ff <= st_rx_wa;
            end
          end
        end
        st_rx_wa: begin
          if (byte_in) begin
            if (is_reg(shreg_ff) || (is_mem(shreg_ff) && mem_on)) begin
              ptr_ff   <= shreg_ff;
              drv_n_ff <= 1'b0;
              state_ff <= st_ack_wa;
            end else begin
              state_ff <= st_idle;
            end
          end
        end
        st_ack_wa: begin
          if (ev.scl_fall) begin
            bitcnt_ff <= 4'h0;
            drv_n_ff  <= 1'b1;
            state_ff  <= st_rx_dat;
          end
        end
        st_rx_dat: begin
          if (byte_in) begin
            if (reg_we || mem_we) begin
              drv_n_ff <= 1'b0;
              ptr_ff   <= step(ptr_ff);
              state_ff <= st_ack_dat;
            end else begin
              state_ff <= st_idle; // locked: access stays a read
            end
          end
        end
        st_ack_dat: begin
          // one byte per frame: further bytes go unanswered
          if (ev.scl_fall) begin
            drv_n_ff <= 1'b1;
            state_ff <= st_idle;
          end
        end
        st_tx: begin
          if (ev.scl_fall) begin
            if (bitcnt_ff == 4'h8) begin
              drv_n_ff <= 1'b1;
              state_ff <= st_mack;
            end else begin
              shreg_ff <= {shreg_ff[6:0], 1'b0};
              drv_n_ff <= shreg_ff[6];
            end
          end
        end
        st_mack: begin
          if (ev.scl_rise) begin
            state_ff <= sda_in ? st_idle : st_ack_dev;
          end
        end
        default: begin
          state_ff <= st_idle;
          drv_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // =============================================
  // mode, unlock and gain registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_ff  <= `ITE_MODE_PDN;
      wen_ff   <= 5'h00;
      xgain_ff <= `ITE_GAIN_RST;
      ygain_ff <= `ITE_GAIN_RST;
      zgain_ff <= `ITE_GAIN_RST;
    end else if (reg_we) begin
      if (ptr_ff == `ITE_ADDR_MODE) begin
        wen_ff <= shreg_ff[`ITE_MS_WEN_MSB:`ITE_MS_WEN_LSB];
        // prohibited code is dropped, mode stays as it was
        if (shreg_ff[`ITE_MS_MODE_MSB:0] != `ITE_MODE_PROHIB) begin
          mode_ff <= shreg_ff[`ITE_MS_MODE_MSB:0];
        end
      end
      if (ptr_ff == `ITE_ADDR_XGAIN) begin
        xgain_ff <= shreg_ff[3:0];
      end
      if (ptr_ff == `ITE_ADDR_YGAIN) begin
        ygain_ff <= shreg_ff[3:0];
      end
      if (ptr_ff == `ITE_ADDR_ZGAIN) begin
        zgain_ff <= shreg_ff[3:0];
      end
    end
  end

  // =============================================
  // reference start-up wait, restarted on every entry to memory mode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      start_cnt_ff <= 16'h0000;
      ready_ff     <= 1'b0;
    end else if (mode_ff != `ITE_MODE_MEM) begin
      start_cnt_ff <= 16'(STARTUP_CYCLES - 1);
      ready_ff     <= 1'b0;
    end else if (start_cnt_ff != 16'h0000) begin
      start_cnt_ff <= start_cnt_ff - 16'h0001;
    end else begin
      ready_ff <= 1'b1;
    end
  end

  // =============================================
  // pending byte, programming cycle and the array itself
  // the word lands at the end of the cycle, so an early relock loses it
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pend_ff      <= 1'b0;
      pend_addr_ff <= 8'h00;
      pend_data_ff <= 8'h00;
      prog_ff      <= 1'b0;
      prog_cnt_ff  <= 20'h00000;
      for (int i = 0; i < `ITE_NUM_WORDS; i++) begin
        mem_ff[i] <= `ITE_TRIM_DEFAULT;
      end
    end else begin
      if (mem_we) begin
        pend_ff      <= 1'b1;
        pend_addr_ff <= ptr_ff;
        pend_data_ff <= shreg_ff;
      end else if (ev.stop && pend_ff) begin
        pend_ff     <= 1'b0;
        prog_ff     <= 1'b1;
        prog_cnt_ff <= 20'(PROG_CYCLES - 1);
      end else if (ev.start) begin
        pend_ff <= 1'b0;
      end
      if (prog_ff) begin
        if (prog_cnt_ff != 20'h00000) begin
          prog_cnt_ff <= prog_cnt_ff - 20'h00001;
        end else begin
          prog_ff <= 1'b0;
          if (!unlocked) begin
            // relocked too early: the byte is dropped
          end else if (pend_addr_ff == `ITE_ADDR_BATCH) begin
            for (int i = 0; i < `ITE_NUM_WORDS; i++) begin
              mem_ff[i] <= pend_data_ff;
            end
          end else begin
            mem_ff[widx(pend_addr_ff)] <= pend_data_ff;
          end
        end
      end
    end
  end

  // =============================================
  // outputs straight from flops, except sda_out tied low
  assign sda_out               = 1'b0; // open drain only ever pulls low
  assign sda_oe_n              = drv_n_ff;
  assign temp_offset_trim      = mem_ff[0];
  assign reference_trim        = mem_ff[1];
  assign drive_oscillator_trim = mem_ff[2];
  assign x_axis_gain_reg       = xgain_ff;
  assign y_axis_gain_reg       = ygain_ff;
  assign z_axis_gain_reg       = zgain_ff;
  assign op_mode               = mode_ff;
  assign ref_ready             = ready_ff;
  assign hv_prog_on            = prog_ff;

endmodule
`default_nettype wire

// ==== verif/ite_props.sv ====
// checker for the trim memory access block: bus drive, modes, programming cycle
// assumes it is bound to ite_eeprom_access and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module ite_props #(
  parameter int STARTUP_CYCLES = 20,
  parameter int PROG_CYCLES    = 50
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // bus pins
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // state under watch
  input wire logic [7:0] temp_offset_trim,
  input wire logic [1:0] op_mode,
  input wire logic       ref_ready,
  input wire logic       hv_prog_on
);
  // =============================================
  // helper counters
  int mode_cnt_ff;
  int prog_cnt_ff;

  // cycles spent in memory mode, saturating so it cannot wrap
  always_ff @(posedge sys_clk) begin
    if (!nrst || op_mode != 2'h2) begin
      mode_cnt_ff <= 0;
    end else if (mode_cnt_ff < STARTUP_CYCLES + 2) begin
      mode_cnt_ff <= mode_cnt_ff + 1;
    end
  end

  // length of the current programming cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst || !hv_prog_on) begin
      prog_cnt_ff <= 0;
    end else begin
      prog_cnt_ff <= prog_cnt_ff + 1;
    end
  end

  // =============================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence prog_begin;
    $rose(hv_prog_on);
  endsequence
  sequence prog_end;
    $fell(hv_prog_on);
  endsequence

  od_drive_a: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  mode_reset_a: assert property (disable iff (1'b0) !nrst |=>
    op_mode == 2'h3 && sda_oe_n && !hv_prog_on && !ref_ready) else $error("reset state wrong");
  mode_legal_a: assert property (op_mode != 2'h1) else $error("prohibited mode");
  ready_late_a: assert property (mode_cnt_ff == STARTUP_CYCLES + 2 && op_mode == 2'h2
    |-> ref_ready) else $error("start-up wait too long");
  ready_early_a: assert property ($rose(ref_ready) |->
    mode_cnt_ff >= STARTUP_CYCLES - 1) else $error("start-up wait too short");
  prog_gate_a: assert property (prog_begin |-> op_mode == 2'h2 && ref_ready)
    else $error("programming outside memory mode");
  prog_len_a: assert property (prog_end |-> prog_cnt_ff >= PROG_CYCLES - 1
    && prog_cnt_ff <= PROG_CYCLES + 1) else $error("programming length wrong");
  prog_max_a: assert property (prog_cnt_ff <= PROG_CYCLES + 1)
    else $error("programming hangs");
  busy_quiet_a: assert property (hv_prog_on |-> sda_oe_n)
    else $error("answer while busy");
  sda_edge_a: assert property (!$stable(sda_oe_n) |-> !scl_in)
    else $error("sda moved, scl high");
  trim_hold_a: assert property (!$stable(temp_offset_trim) |-> $past(hv_prog_on)
    && !hv_prog_on) else $error("trim changed outside programming");
endmodule

bind ite_eeprom_access ite_props #(
  .STARTUP_CYCLES(STARTUP_CYCLES),
  .PROG_CYCLES   (PROG_CYCLES)
) props (
  .sys_clk         (sys_clk),
  .nrst            (nrst),
  .scl_in          (scl_in),
  .sda_out         (sda_out),
  .sda_oe_n        (sda_oe_n),
  .temp_offset_trim(temp_offset_trim),
  .op_mode         (op_mode),
  .ref_ready       (ref_ready),
  .hv_prog_on      (hv_prog_on)
);
`default_nettype wire

// ==== verif/ite_host_model.sv ====
// bus master model: start, stop, byte transfers and whole frames at 400 kHz
// assumes sda is open drain with a pull-up resolved by the bench
`include "ite_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ite_host_model (
  // clock
  input  wire logic       sys_clk,
  // bus lines, sda_m high means released
  output logic            scl,
  output logic            sda_m,
  input  wire logic       sda_w,
  // straps the master believes the device has
  input  wire logic [1:0] sel
);
  // 150 + 100 cycles of 10 ns make a 400 kHz bit
  localparam int LOW  = 150;
  localparam int HIGH = 100;

  // lines idle high
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // also serves as repeated start from scl low
  task automatic start();
    sda_m = 1'b1;
    tick(LOW);
    scl = 1'b1;
    tick(HIGH);
    sda_m = 1'b0;
    tick(HIGH);
    scl = 1'b0;
    tick(1);
  endtask

  // data changes one cycle after scl falls, never with it
  task automatic xfer(input logic b, output logic r);
    sda_m = b;
    tick(LOW - 1);
    scl = 1'b1;
    tick(HIGH);
    r   = sda_w;
    scl = 1'b0;
    tick(1);
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(b[i], r);
    end
    xfer(1'b1, ack);
  endtask

  // last byte answered by nack; the caller sends the stop
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(last, r);
  endtask

  task automatic stop();
    sda_m = 1'b0;
    tick(LOW);
    scl = 1'b1;
    tick(HIGH);
    sda_m = 1'b1;
    tick(LOW);
  endtask

  // one byte, then stop at once
  task automatic wr(input logic [7:0] wa, input logic [7:0] d, output logic [2:0] acks);
    start();
    send({`ITE_SLAVE_BASE, sel, 1'b0}, acks[2]);
    send(wa, acks[1]);
    send(d, acks[0]);
    stop();
  endtask

  // dummy write of the word address before a random read
  task automatic rd(input logic rnd, input logic [7:0] wa, output logic [7:0] d,
                    output logic [1:0] acks);
    logic a;
    acks = 2'b00;
    if (rnd) begin
      start();
      send({`ITE_SLAVE_BASE, sel, 1'b0}, a);
      send(wa, acks[1]);
      acks[1] = acks[1] | a;
    end
    start();
    send({`ITE_SLAVE_BASE, sel, 1'b1}, acks[0]);
    recv(1'b1, d);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== verif/ite_eeprom_access_tb.sv ====
// testbench for the trim memory access block: reference model and scenarios
// assumes the host model drives the bus and the checker is bound to the design
`timescale 1ns/1ps
`default_nettype none
module ite_eeprom_access_tb;
  localparam int PROG = 400;
  // =============================================
  // signals
  logic       sys_clk;
  logic       nrst;
  logic [1:0] straps;
  logic [1:0] sel_h;
  wire  logic scl;
  wire  logic sda_m;
  wire  logic sda_w;
  logic       sda_out;
  logic       sda_oe_n;
  logic [7:0] temp_offset_trim;
  logic [7:0] reference_trim;
  logic [7:0] drive_oscillator_trim;
  logic [3:0] x_axis_gain_reg;
  logic [3:0] y_axis_gain_reg;
  logic [3:0] z_axis_gain_reg;
  logic [1:0] op_mode;
  logic       ref_ready;
  logic       hv_prog_on;
  logic [7:0] d;
  logic [7:0] dv;
  logic [1:0] ak;
  logic [2:0] a3;
  logic [7:0] wl [4] = '{8'h62, 8'h63, 8'h64, 8'h68};
  int         miscompares = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         mem [int];
  int         cnt;

  // pull-up wins unless a party pulls low
  assign sda_w = sda_m & (sda_oe_n | sda_out);

  ite_eeprom_access #(.STARTUP_CYCLES(20), .PROG_CYCLES(PROG)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_0(straps[0]), .addr_select_1(straps[1]),
    .temp_offset_trim(temp_offset_trim), .reference_trim(reference_trim),
    .drive_oscillator_trim(drive_oscillator_trim), .x_axis_gain_reg(x_axis_gain_reg),
    .y_axis_gain_reg(y_axis_gain_reg), .z_axis_gain_reg(z_axis_gain_reg),
    .op_mode(op_mode), .ref_ready(ref_ready), .hv_prog_on(hv_prog_on));

  ite_host_model host (.sys_clk(sys_clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w), .sel(sel_h));

  // =============================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // scenarios take about 120k cycles; the ceiling leaves margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 150000) begin
      miscompares++;
      results();
    end
  end

  // =============================================
  // compare, verdict, reference model
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // counter wraps from the last trim word back to the first
  function automatic int nxt(int a);
    return (a == 'h68) ? 'h62 : (a + 1) % 256;
  endfunction

  function automatic int m_rd(int a);
    cnt = nxt(a);
    return mem[a];
  endfunction

  // bounded wait for the end of programming
  task automatic wait_prog();
    for (int i = 0; i < PROG + 20 && hv_prog_on; i++) @(negedge sys_clk);
    chk(hv_prog_on, 1'b0);
  endtask

  // =============================================
  // scenarios
  initial begin
    void'($urandom(32'h5338));
    nrst   = 1'b0;
    straps = 2'($urandom);
    sel_h  = straps;
    for (int a = 'h60; a <= 'h68; a++) mem[a] = 0;
    cnt = 'h62;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    // reset state and status
    chk(op_mode, 8'h03);
    chk(temp_offset_trim, 8'h00);
    chk(x_axis_gain_reg, 8'h00);
    chk(y_axis_gain_reg, 8'h00);
    host.rd(1'b1, 8'hc0, d, ak);
    chk(d, 8'h00);
    // frame to another slave is ignored
    sel_h = ~straps;
    host.rd(1'b0, 8'h00, d, ak);
    chk(ak[0], 1'b1);
    sel_h = straps;
    // memory mode with writes unlocked
    host.wr(8'he0, 8'haa, a3);
    chk(op_mode, 8'h02);
    chk(ref_ready, 1'b1);
    host.rd(1'b1, 8'hc0, d, ak);
    chk(d, 8'h02);
    // byte writes, last one at the top of the map
    foreach (wl[i]) begin
      dv = 8'($urandom);
      host.wr(wl[i], dv, a3);
      chk(a3, 8'h00);
      chk(hv_prog_on, 1'b1);
      wait_prog();
      mem[wl[i]] = dv;
      cnt = nxt(wl[i]);
    end
    chk(temp_offset_trim, 8'(mem['h62]));
    chk(reference_trim, 8'(mem['h63]));
    chk(drive_oscillator_trim, 8'(mem['h64]));
    // current reads after the wrap
    for (int i = 0; i < 2; i++) begin
      host.rd(1'b0, 8'h00, d, ak);
      chk(ak[0], 1'b0);
      chk(d, 8'(m_rd(cnt)));
    end
    // random read of 63H, then a current read of the next word
    host.rd(1'b1, 8'h63, d, ak);
    chk(ak, 8'h00);
    chk(d, 8'(m_rd('h63)));
    host.rd(1'b0, 8'h00, d, ak);
    chk(d, 8'(m_rd(cnt)));
    // relock with the prohibited mode code, then a write is refused
    host.wr(8'he0, 8'h01, a3);
    chk(op_mode, 8'h02);
    host.wr(8'h66, 8'($urandom), a3);
    chk(a3[0], 1'b1);
    chk(hv_prog_on, 1'b0);
    // host copies a gain word into its gain register
    host.wr(8'he6, 8'(mem['h68]), a3);
    chk(z_axis_gain_reg, 8'(mem['h68] & 'hf));
    chk(x_axis_gain_reg, 8'h00);
    chk(y_axis_gain_reg, 8'h00);
    // back to power-down
    host.wr(8'he0, 8'h03, a3);
    chk(op_mode, 8'h03);
    results();
  end
endmodule
`default_nettype wire
